// File: rtl/fpmc_defines.svh
// Constants of the flash program memory sequencer.
//
// Contract
// - Row write programs 32 words (96 bytes).
// - Erase blocks of 8, 32, 64 or 128 words.
// - Erase size from command bits one and zero.
// - Target address is table page plus address.
// - Low table access reaches bits 15 to 0.
// - High table access reaches bits 23 to 16.
// - Enable bit gates cycles, cleared on completion.
// - Abort flag set when reset cuts cycle.
// - Skip-erase bit, when set, omits erase before write.
// - Erase-select bit gives command erase or write.
// - Erase code 011010 erases eight words.
// - Visibility bit 15 comes from page bit 0.
// - Visibility page takes only 00 or ff.
// - Serial programmer uses clock, data, entry level.
`ifndef FPMC_DEFINES_SVH
`define FPMC_DEFINES_SVH
// ****************************************************************
// Register offsets.
// ****************************************************************
`define FPMC_OFS_CTRL 4'h0
`define FPMC_OFS_TPAGE 4'h1
`define FPMC_OFS_VPAGE 4'h2
`define FPMC_OFS_STAT 4'h3
`define FPMC_OFS_CLR 4'h4
`define FPMC_OFS_IEN 4'h5
// ****************************************************************
// Control fields.
// ****************************************************************
`define FPMC_BIT_START 15
`define FPMC_BIT_EN 14
`define FPMC_BIT_ABORT 13
`define FPMC_BIT_SKIP 12
`define FPMC_BIT_ERASE 6
`define FPMC_CTRL_RESET 16'h0000
`define FPMC_ERASE8_OP 6'h1a
`define FPMC_SINGLE_OP 3'h1
`define FPMC_VPAGE_PROG 8'h00
`define FPMC_VPAGE_EE 8'hff
// ****************************************************************
// Sizes and timing.
// ****************************************************************
`define FPMC_ROW_WORDS 32
`define FPMC_CLK_MHZ 100
`define FPMC_ERASE_NS 20000
`define FPMC_PROG_NS 1000
`define FPMC_ERASE_CYC ((`FPMC_ERASE_NS * `FPMC_CLK_MHZ + 999) / 1000)
`define FPMC_PROG_CYC ((`FPMC_PROG_NS * `FPMC_CLK_MHZ + 999) / 1000)
`define FPMC_SER_BITS 48
// Interrupt status bits.
`define FPMC_IRQ_DONE 0
`define FPMC_IRQ_ABORT 1
`define FPMC_IRQ_SER 2
`endif

// File: rtl/fpmc_pkg.sv
// Types of the flash program memory sequencer.
package fpmc_pkg;
    typedef logic [23:0] fpmc_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ERASE_WAIT = 3'b001,
        ST_ERASE_RUN = 3'b010,
        ST_PROG_WAIT = 3'b011,
        ST_PROG_RUN = 3'b100,
        ST_SER_WAIT = 3'b101
    } fpmc_state_e;
endpackage

// File: rtl/fpmc_flash_if.sv
// Connection between the sequencer and the flash array.
`timescale 1ns/1ps
interface fpmc_flash_if #(parameter int AW = 10);
    logic [AW-1:0] rd_addr;
    fpmc_pkg::fpmc_word_t rd_data;
    logic wr;
    logic [AW-1:0] wr_addr;
    fpmc_pkg::fpmc_word_t wr_data;
    modport seq (output rd_addr, output wr, output wr_addr, output wr_data, input rd_data);
    modport array (input rd_addr, input wr, input wr_addr, input wr_data, output rd_data);
endinterface

// File: rtl/fpmc_flash_array.sv
// Flash program word array with one write and one read port.
`timescale 1ns/1ps
module fpmc_flash_array #(
    parameter int WORDS = 1024,
    parameter int AW = 10
) (
    input wire logic clk_in,
    fpmc_flash_if.array fl
);
    fpmc_pkg::fpmc_word_t mem [WORDS];

    always_ff @(posedge clk_in) begin
        if (fl.wr && (int'(fl.wr_addr) < WORDS)) begin
            mem[fl.wr_addr] <= fl.wr_data;
        end
    end

    assign fl.rd_data = (int'(fl.rd_addr) < WORDS) ? mem[fl.rd_addr] : 24'h000000;
endmodule

// File: rtl/fpmc_top.sv
// Flash program memory self-programming sequencer with serial programming port.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "fpmc_defines.svh"
module fpmc_top #(
    parameter int WORDS = 1024,
    parameter int AW = 10,
    parameter int ERASE_CYC = `FPMC_ERASE_CYC,
    parameter int PROG_CYC = `FPMC_PROG_CYC
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [15:0] REG_RDATA_OUT,
    input wire logic TBL_RD_IN,
    input wire logic TBL_WR_IN,
    input wire logic TBL_HIGH_IN,
    input wire logic TBL_BYTE_IN,
    input wire logic [15:0] TBL_EFF_ADDR_IN,
    input wire logic [15:0] TBL_WDATA_IN,
    input wire logic VIS_RD_IN,
    input wire logic [15:0] VIS_EFF_ADDR_IN,
    output logic [15:0] TBL_RDATA_OUT,
    output logic TBL_ACK_OUT,
    input wire logic MASTER_CLEAR_B_IN,
    input wire logic WDT_RST_IN,
    input wire logic PROG_ENTRY_IN,
    input wire logic SER_CLK_IN,
    input wire logic SER_DATA_IN,
    output logic SER_DATA_OUT,
    output logic SER_DATA_OE_OUT,
    output logic BUSY_OUT,
    output logic IRQ_OUT
);
    // ****************************************************************
    // Reset release and pin synchronisers.
    // ****************************************************************
    logic rst_meta_q;
    logic rst_b_q;
    logic [3:0] pin_raw;
    logic [3:0] pin_f;
    logic ser_clk_prev_q;
    logic ser_rise;

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_meta_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_b_q <= rst_meta_q;
        end
    end

    assign pin_raw = {MASTER_CLEAR_B_IN, PROG_ENTRY_IN, SER_DATA_IN, SER_CLK_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic f_q;
            always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
                if (!rst_b_q) begin
                    s1_q <= (gi == 3) ? 1'b1 : 1'b0;
                    s2_q <= (gi == 3) ? 1'b1 : 1'b0;
                    s3_q <= (gi == 3) ? 1'b1 : 1'b0;
                    f_q <= (gi == 3) ? 1'b1 : 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        f_q <= s3_q;
                    end
                end
            end
            assign pin_f[gi] = f_q;
        end
    endgenerate

    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ser_clk_prev_q <= 1'b0;
        end else begin
            ser_clk_prev_q <= pin_f[0];
        end
    end
    assign ser_rise = pin_f[0] && !ser_clk_prev_q;

    // ****************************************************************
    // Registers and shared state.
    // ****************************************************************
    logic start_q;
    logic en_q;
    logic abort_q;
    logic skip_q;
    logic erase_q;
    logic [5:0] op_q;
    logic [7:0] tpage_q;
    logic [7:0] vpage_q;
    logic [2:0] stat_q;
    logic [2:0] ien_q;
    fpmc_pkg::fpmc_state_e st_q;
    logic busy;
    logic reg_wr_ctrl;
    logic go;
    logic abort_ev;
    logic done_ev;
    logic ser_ev;
    logic [7:0] erase_n;
    logic ser_pend_q;
    logic ser_take;
    logic [23:0] ser_addr_q;
    fpmc_pkg::fpmc_word_t ser_data_q;

    function automatic logic [7:0] erase_words(input logic [5:0] op);
        logic [7:0] n;
        n = 8'h00;
        if (op[5:2] == 4'b0110) begin
            case (op[1:0])
                2'b00: n = 8'h20;
                2'b01: n = 8'h40;
                2'b10: n = 8'h08;
                2'b11: n = 8'h80;
                default: n = 8'h00;
            endcase
        end
        return n;
    endfunction

    assign busy = (st_q != fpmc_pkg::ST_IDLE);
    assign reg_wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `FPMC_OFS_CTRL);
    assign go = reg_wr_ctrl && !busy && REG_WDATA_IN[`FPMC_BIT_START]
        && REG_WDATA_IN[`FPMC_BIT_EN];
    assign abort_ev = busy && (st_q != fpmc_pkg::ST_SER_WAIT)
        && (!pin_f[3] || WDT_RST_IN);
    assign erase_n = erase_words(op_q);

    // Control register.
    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            start_q <= 1'b0;
            en_q <= 1'b0;
            abort_q <= 1'b0;
            skip_q <= 1'b0;
            erase_q <= 1'b0;
            op_q <= 6'h00;
        end else begin
            if (reg_wr_ctrl && !busy) begin
                en_q <= REG_WDATA_IN[`FPMC_BIT_EN];
                abort_q <= REG_WDATA_IN[`FPMC_BIT_ABORT];
                skip_q <= REG_WDATA_IN[`FPMC_BIT_SKIP];
                erase_q <= REG_WDATA_IN[`FPMC_BIT_ERASE];
                op_q <= REG_WDATA_IN[5:0];
            end
            if (go) begin
                start_q <= 1'b1;
            end
            if (done_ev || abort_ev) begin
                start_q <= 1'b0;
                en_q <= 1'b0;
            end
            if (done_ev) begin
                abort_q <= 1'b0;
            end
            if (abort_ev) begin
                abort_q <= 1'b1;
            end
        end
    end

    // Page registers.
    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            tpage_q <= 8'h00;
            vpage_q <= `FPMC_VPAGE_PROG;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `FPMC_OFS_TPAGE) begin
                tpage_q <= REG_WDATA_IN[7:0];
            end
            if (REG_ADDR_IN == `FPMC_OFS_VPAGE && (REG_WDATA_IN[7:0] == `FPMC_VPAGE_PROG
                || REG_WDATA_IN[7:0] == `FPMC_VPAGE_EE)) begin
                vpage_q <= REG_WDATA_IN[7:0];
            end
        end
    end

    // Interrupt status, enable and output.
    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            stat_q <= 3'h0;
            ien_q <= 3'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            if (REG_WR_IN && REG_ADDR_IN == `FPMC_OFS_IEN) begin
                ien_q <= REG_WDATA_IN[2:0];
            end
            stat_q <= (stat_q & ~((REG_WR_IN && REG_ADDR_IN == `FPMC_OFS_CLR)
                ? REG_WDATA_IN[2:0] : 3'h0)) | {ser_ev, abort_ev, done_ev};
            IRQ_OUT <= |(stat_q & ien_q);
        end
    end

    // Register read port.
    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            REG_RDATA_OUT <= 16'h0000;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                `FPMC_OFS_CTRL: REG_RDATA_OUT <= {start_q, en_q, abort_q, skip_q, 5'h00,
                    erase_q, op_q};
                `FPMC_OFS_TPAGE: REG_RDATA_OUT <= {8'h00, tpage_q};
                `FPMC_OFS_VPAGE: REG_RDATA_OUT <= {8'h00, vpage_q};
                `FPMC_OFS_STAT: REG_RDATA_OUT <= {13'h0000, stat_q};
                `FPMC_OFS_IEN: REG_RDATA_OUT <= {13'h0000, ien_q};
                default: REG_RDATA_OUT <= 16'h0000;
            endcase
        end else begin
            REG_RDATA_OUT <= 16'h0000;
        end
    end

    // ****************************************************************
    // Table access and row latches.
    // ****************************************************************
    fpmc_pkg::fpmc_word_t latch_q [`FPMC_ROW_WORDS];
    logic [23:0] tbl_addr;
    logic [23:0] vis_addr;
    logic [23:0] tgt_q;
    logic [AW-1:0] rd_idx;
    fpmc_pkg::fpmc_word_t rd_word;
    logic rd_lane;
    logic rd_high;
    logic rd_ee;
    logic rd_pend;

    fpmc_flash_if #(.AW(AW)) fl ();

    assign tbl_addr = {tpage_q, TBL_EFF_ADDR_IN};
    assign vis_addr = {1'b0, vpage_q[7:1], vpage_q[0], VIS_EFF_ADDR_IN[14:0]};
    assign rd_idx = VIS_RD_IN ? vis_addr[AW:1] : tbl_addr[AW:1];
    assign fl.rd_addr = rd_idx;
    assign rd_word = fl.rd_data;

    always_ff @(posedge CLK_SYS_IN) begin
        if (TBL_WR_IN) begin
            if (!TBL_HIGH_IN && (!TBL_BYTE_IN || !TBL_EFF_ADDR_IN[0])) begin
                latch_q[TBL_EFF_ADDR_IN[5:1]][7:0] <= TBL_WDATA_IN[7:0];
            end
            if (!TBL_HIGH_IN && !TBL_BYTE_IN) begin
                latch_q[TBL_EFF_ADDR_IN[5:1]][15:8] <= TBL_WDATA_IN[15:8];
            end else if (!TBL_HIGH_IN && TBL_EFF_ADDR_IN[0]) begin
                latch_q[TBL_EFF_ADDR_IN[5:1]][15:8] <= TBL_WDATA_IN[7:0];
            end
            if (TBL_HIGH_IN && !(TBL_BYTE_IN && TBL_EFF_ADDR_IN[0])) begin
                latch_q[TBL_EFF_ADDR_IN[5:1]][23:16] <= TBL_WDATA_IN[7:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            tgt_q <= 24'h000000;
        end else if (TBL_WR_IN) begin
            tgt_q <= tbl_addr;
        end
    end

    assign rd_pend = TBL_RD_IN || VIS_RD_IN;
    assign rd_lane = VIS_RD_IN ? VIS_EFF_ADDR_IN[0] : TBL_EFF_ADDR_IN[0];
    assign rd_high = TBL_HIGH_IN && !VIS_RD_IN;
    assign rd_ee = VIS_RD_IN && (vpage_q == `FPMC_VPAGE_EE);

    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            TBL_RDATA_OUT <= 16'h0000;
            TBL_ACK_OUT <= 1'b0;
        end else begin
            TBL_ACK_OUT <= TBL_RD_IN || TBL_WR_IN || VIS_RD_IN;
            if (!rd_pend || rd_ee) begin
                TBL_RDATA_OUT <= 16'h0000;
            end else if (rd_high) begin
                TBL_RDATA_OUT <= (TBL_BYTE_IN && rd_lane) ? 16'h0000
                    : {8'h00, rd_word[23:16]};
            end else if (TBL_BYTE_IN) begin
                TBL_RDATA_OUT <= {8'h00, rd_lane ? rd_word[15:8] : rd_word[7:0]};
            end else begin
                TBL_RDATA_OUT <= rd_word[15:0];
            end
        end
    end

    // ****************************************************************
    // Serial programming port.
    // ****************************************************************
    logic [47:0] ser_sh_q;
    logic [5:0] ser_cnt_q;

    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ser_sh_q <= 48'h000000000000;
            ser_cnt_q <= 6'h00;
            ser_pend_q <= 1'b0;
            ser_addr_q <= 24'h000000;
            ser_data_q <= 24'h000000;
        end else begin
            if (ser_take) begin
                ser_pend_q <= 1'b0;
            end
            if (!pin_f[2] || !pin_f[3]) begin
                ser_cnt_q <= 6'h00;
            end else if (ser_rise) begin
                ser_sh_q <= {ser_sh_q[46:0], pin_f[1]};
                if (ser_cnt_q == 6'(`FPMC_SER_BITS - 1)) begin
                    ser_cnt_q <= 6'h00;
                    ser_pend_q <= 1'b1;
                    ser_addr_q <= ser_sh_q[46:23];
                    ser_data_q <= {ser_sh_q[22:0], pin_f[1]};
                end else begin
                    ser_cnt_q <= ser_cnt_q + 6'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Program and erase sequencer.
    // ****************************************************************
    logic [15:0] wait_q;
    logic [7:0] idx_q;
    logic [7:0] cnt_q;
    logic [AW-1:0] base_q;
    logic prog_after_q;
    logic single_q;
    logic run_last;
    logic [AW-1:0] seq_addr;

    assign ser_take = (st_q == fpmc_pkg::ST_IDLE) && ser_pend_q && !go;
    assign run_last = (idx_q == cnt_q - 8'h01);
    assign done_ev = !abort_ev && (((st_q == fpmc_pkg::ST_PROG_RUN
        || (st_q == fpmc_pkg::ST_ERASE_RUN && !prog_after_q)) && run_last)
        || (st_q == fpmc_pkg::ST_ERASE_WAIT && cnt_q == 8'h00));
    assign ser_ev = (st_q == fpmc_pkg::ST_SER_WAIT) && (wait_q == 16'h0000);
    assign seq_addr = single_q ? base_q : (base_q | AW'(idx_q));

    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            st_q <= fpmc_pkg::ST_IDLE;
            wait_q <= 16'h0000;
            idx_q <= 8'h00;
            cnt_q <= 8'h00;
            base_q <= '0;
            prog_after_q <= 1'b0;
            single_q <= 1'b0;
        end else if (abort_ev) begin
            st_q <= fpmc_pkg::ST_IDLE;
        end else begin
            case (st_q)
                fpmc_pkg::ST_IDLE: begin
                    idx_q <= 8'h00;
                    if (go) begin
                        single_q <= !REG_WDATA_IN[`FPMC_BIT_ERASE]
                            && (REG_WDATA_IN[5:3] == `FPMC_SINGLE_OP);
                        if (REG_WDATA_IN[`FPMC_BIT_ERASE]) begin
                            cnt_q <= erase_words(REG_WDATA_IN[5:0]);
                            base_q <= tgt_q[AW:1] & ~AW'(erase_words(REG_WDATA_IN[5:0]) - 8'h01);
                            prog_after_q <= 1'b0;
                            wait_q <= 16'(ERASE_CYC - 1);
                            st_q <= fpmc_pkg::ST_ERASE_WAIT;
                        end else begin
                            if (REG_WDATA_IN[5:3] == `FPMC_SINGLE_OP) begin
                                cnt_q <= 8'h01;
                                base_q <= tgt_q[AW:1];
                            end else begin
                                cnt_q <= 8'(`FPMC_ROW_WORDS);
                                base_q <= tgt_q[AW:1] & ~AW'(`FPMC_ROW_WORDS - 1);
                            end
                            prog_after_q <= 1'b1;
                            if (REG_WDATA_IN[`FPMC_BIT_SKIP]) begin
                                wait_q <= 16'(PROG_CYC - 1);
                                st_q <= fpmc_pkg::ST_PROG_WAIT;
                            end else begin
                                wait_q <= 16'(ERASE_CYC - 1);
                                st_q <= fpmc_pkg::ST_ERASE_WAIT;
                            end
                        end
                    end else if (ser_pend_q) begin
                        wait_q <= 16'(PROG_CYC - 1);
                        st_q <= fpmc_pkg::ST_SER_WAIT;
                    end
                end
                fpmc_pkg::ST_ERASE_WAIT: begin
                    if (cnt_q == 8'h00) begin
                        st_q <= fpmc_pkg::ST_IDLE;
                    end else if (wait_q == 16'h0000) begin
                        st_q <= fpmc_pkg::ST_ERASE_RUN;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                fpmc_pkg::ST_ERASE_RUN: begin
                    idx_q <= idx_q + 8'h01;
                    if (run_last) begin
                        idx_q <= 8'h00;
                        wait_q <= 16'(PROG_CYC - 1);
                        st_q <= prog_after_q ? fpmc_pkg::ST_PROG_WAIT : fpmc_pkg::ST_IDLE;
                    end
                end
                fpmc_pkg::ST_PROG_WAIT: begin
                    if (wait_q == 16'h0000) begin
                        st_q <= fpmc_pkg::ST_PROG_RUN;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                fpmc_pkg::ST_PROG_RUN: begin
                    idx_q <= idx_q + 8'h01;
                    if (run_last) begin
                        st_q <= fpmc_pkg::ST_IDLE;
                    end
                end
                fpmc_pkg::ST_SER_WAIT: begin
                    if (wait_q == 16'h0000) begin
                        st_q <= fpmc_pkg::ST_IDLE;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                default: st_q <= fpmc_pkg::ST_IDLE;
            endcase
        end
    end

    // Array write port.
    always_comb begin
        fl.wr = 1'b0;
        fl.wr_addr = seq_addr;
        fl.wr_data = 24'hffffff;
        if (abort_ev) begin
            fl.wr = 1'b0;
        end else if (st_q == fpmc_pkg::ST_ERASE_RUN) begin
            fl.wr = 1'b1;
        end else if (st_q == fpmc_pkg::ST_PROG_RUN) begin
            fl.wr = 1'b1;
            fl.wr_data = latch_q[seq_addr[4:0]];
        end else if (ser_ev) begin
            fl.wr = 1'b1;
            fl.wr_addr = ser_addr_q[AW:1];
            fl.wr_data = ser_data_q;
        end
    end

    fpmc_flash_array #(
        .WORDS(WORDS),
        .AW(AW)
    ) u_array (
        .clk_in(CLK_SYS_IN),
        .fl(fl)
    );

    // Status pins: busy and the serial data line held low while a word programs.
    always_ff @(posedge CLK_SYS_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            BUSY_OUT <= 1'b0;
            SER_DATA_OUT <= 1'b0;
            SER_DATA_OE_OUT <= 1'b0;
        end else begin
            BUSY_OUT <= busy || go;
            SER_DATA_OUT <= 1'b0;
            SER_DATA_OE_OUT <= ser_pend_q || (st_q == fpmc_pkg::ST_SER_WAIT);
        end
    end
endmodule

// File: sim/fpmc_top_monitor.sv
// Port checks of the flash sequencer.
`timescale 1ns/1ps
module fpmc_top_monitor (
    input wire logic CLK_SYS_IN, RST_B_IN, REG_WR_IN, TBL_RD_IN, TBL_WR_IN, VIS_RD_IN,
    input wire logic WDT_RST_IN, BUSY_OUT, TBL_ACK_OUT, SER_DATA_OUT,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN, TBL_RDATA_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);
    wire logic go = REG_WR_IN && REG_ADDR_IN == 4'h0 && !BUSY_OUT;
    wire logic st = TBL_RD_IN || TBL_WR_IN || VIS_RD_IN;
    chk_start_busy: assert property (go && REG_WDATA_IN[15:14] == 2'b11 |=> BUSY_OUT)
        else $error("start did not raise busy");
    chk_no_enable: assert property (go && REG_WDATA_IN[15:14] == 2'b10 |=> !BUSY_OUT)
        else $error("start without enable ran");
    chk_busy_bound: assert property ($rose(BUSY_OUT) |-> ##[1:600] !BUSY_OUT)
        else $error("cycle never ended");
    chk_abort_stop: assert property (WDT_RST_IN && BUSY_OUT |-> ##[1:8] !BUSY_OUT)
        else $error("watchdog did not stop cycle");
    chk_ack_pulse: assert property (st |=> TBL_ACK_OUT)
        else $error("table access not acknowledged");
    chk_ack_cause: assert property (TBL_ACK_OUT |-> $past(st))
        else $error("acknowledge without access");
    chk_rdata_idle: assert property (!$past(TBL_RD_IN) && !$past(VIS_RD_IN)
        |-> TBL_RDATA_OUT == 16'h0)
        else $error("table read data not idle");
    chk_ser_quiet: assert property (!SER_DATA_OUT)
        else $error("serial data driven high");
endmodule
bind fpmc_top fpmc_top_monitor fpmc_top_monitor_i (.CLK_SYS_IN, .RST_B_IN, .REG_WR_IN,
    .TBL_RD_IN, .TBL_WR_IN, .VIS_RD_IN, .WDT_RST_IN, .BUSY_OUT, .TBL_ACK_OUT, .SER_DATA_OUT,
    .REG_ADDR_IN, .REG_WDATA_IN, .TBL_RDATA_OUT);

// File: sim/fpmc_ser_prog.sv
// Serial programmer model driving clock, data and entry pins.
`timescale 1ns/1ps
module fpmc_ser_prog (
    input wire logic clk_in,
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic entry_out
);
    initial {ser_clk_out, ser_data_out, entry_out} = 3'b000;
    task automatic send(logic [47:0] f);
        entry_out <= 1'b1;
        for (int i = 47; i >= 0; i--) begin
            @(posedge clk_in) ser_data_out <= f[i];
            repeat (4) @(posedge clk_in);
            ser_clk_out <= 1'b1;
            repeat (5) @(posedge clk_in);
            ser_clk_out <= 1'b0;
        end
        repeat (5) @(posedge clk_in);
        ser_data_out <= ~f[0];
    endtask
endmodule

// File: sim/tb_fpmc_top.sv
// Self-checking bench of the flash sequencer.
`timescale 1ns/1ps
module tb_fpmc_top;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, twr = 0, trd = 0, vrd = 0, hi = 0, wdt = 0;
    logic [3:0] a = 0;
    logic [15:0] d = 0, eff = 0, tw = 0, rdat, tdat, r;
    logic ack, so, soe, busy, irq, sclk, sdat, entry;
    logic mstr_clr_b = 1, byt = 0;
    logic [23:0] m [32];
    logic [5:0] ec [4] = '{6'h1a, 6'h18, 6'h19, 6'h1b};
    int sz [4] = '{8, 32, 64, 128};
    int fail_count = 0, cmp_count = 0, k, n [5];
    fpmc_top #(.ERASE_CYC(8), .PROG_CYC(4)) fpmc_top_i (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
        .REG_ADDR_IN(a), .REG_WDATA_IN(d), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
        .TBL_RD_IN(trd), .TBL_WR_IN(twr), .TBL_HIGH_IN(hi), .TBL_BYTE_IN(byt),
        .TBL_EFF_ADDR_IN(eff), .TBL_WDATA_IN(tw), .VIS_RD_IN(vrd), .VIS_EFF_ADDR_IN(eff),
        .TBL_RDATA_OUT(tdat), .TBL_ACK_OUT(ack), .MASTER_CLEAR_B_IN(mstr_clr_b),
        .WDT_RST_IN(wdt), .PROG_ENTRY_IN(entry), .SER_CLK_IN(sclk),
        .SER_DATA_IN(soe ? so : sdat), .SER_DATA_OUT(so), .SER_DATA_OE_OUT(soe), .BUSY_OUT(busy),
        .IRQ_OUT(irq));
    fpmc_ser_prog fpmc_ser_prog_i (.clk_in(clk), .ser_clk_out(sclk), .ser_data_out(sdat),
        .entry_out(entry));
    initial forever #5 clk = ~clk;
    task automatic chk(string s, logic [23:0] e, logic [23:0] v);
        cmp_count++;
        if (v !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, v);
            fail_count++;
        end
    endtask
    function automatic int busy_len(int w, bit e, bit p);
        return 1 + (e ? 8 + w : 0) + (p ? 4 + w : 0);
    endfunction
    task automatic rg(bit w, logic [3:0] ad, logic [15:0] dt);
        @(posedge clk) {wr, rd, a, d} <= {w, !w, ad, dt};
        @(posedge clk) {wr, rd} <= 2'b00;
        #1 r = rdat;
    endtask
    task automatic tb(int md, bit h, logic [15:0] ad, logic [15:0] dt);
        @(posedge clk) {twr, trd, vrd, hi, eff, tw} <= {md == 1, md == 0, md == 2, h, ad, dt};
        @(posedge clk) {twr, trd, vrd} <= 3'b000;
        #1 r = tdat;
        chk("ack", 24'h1, ack);
    endtask
    task automatic go(logic [15:0] c, output int t);
        rg(1, 0, c);
        for (t = 0; busy === 1'b1 && t < 900; t++)
            @(posedge clk) #1;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(25));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rg(1, 2, 16'h0012);
        rg(0, 2, 0);
        chk("vpage", 24'h0, r);
        rg(1, 1, 0);
        for (int i = 0; i < 32; i++) begin
            m[i] = $urandom;
            tb(1, 0, 16'(16'h40 + 2 * i), m[i][15:0]);
            tb(1, 1, 16'(16'h40 + 2 * i), {8'h0, m[i][23:16]});
        end
        go(16'hc000, k);
        rg(0, 0, 0);
        chk("ctrl", 24'h0, r);
        for (int i = 0; i < 32; i++) begin
            tb(0, 0, 16'(16'h40 + 2 * i), 0);
            chk("low", m[i][15:0], r);
            tb(0, 1, 16'(16'h40 + 2 * i), 0);
            chk("high", m[i][23:16], r);
        end
        tb(2, 0, 16'h8040, 0);
        chk("vis", m[0][15:0], r);
        rg(1, 2, 16'h00ff);
        tb(2, 0, 16'h8040, 0);
        chk("vis_ee", 24'h0, r);
        rg(1, 2, 16'h0000);
        rg(1, 0, 16'h8000);
        rg(0, 0, 0);
        chk("no_enable", 24'h0, r[15]);
        go(16'hd000, n[0]);
        go(16'hd008, n[1]);
        chk("row", busy_len(32, 0, 1), n[0]);
        chk("single", busy_len(1, 0, 1), n[1]);
        chk("erase_first", busy_len(32, 1, 1), k);
        go(16'hc05a, k);
        tb(0, 0, 16'h007e, 0);
        chk("erased", 24'hffff, r);
        tb(0, 0, 16'h006e, 0);
        chk("kept", m[23][15:0], r);
        foreach (ec[j]) begin
            go(16'hc040 | ec[j], n[j + 1]);
            chk("erase_len", busy_len(sz[j], 1, 0), n[j + 1]);
        end
        rg(1, 5, 16'h0002);
        rg(1, 0, 16'hc05b);
        repeat (4) @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        repeat (10) @(posedge clk);
        rg(0, 0, 0);
        chk("abort", 24'h1, r[13]);
        chk("irq", 24'h1, irq);
        rg(1, 4, 16'h0007);
        @(posedge clk);
        #1 chk("irq_clr", 24'h0, irq);
        rg(1, 0, 16'hc05b);
        @(posedge clk) mstr_clr_b <= 1'b0;
        repeat (8) @(posedge clk);
        mstr_clr_b <= 1'b1;
        rg(0, 0, 0);
        chk("clear_abort", 24'h1, r[13]);
        m[0] = $urandom;
        fpmc_ser_prog_i.send({24'h000080, m[0]});
        for (k = 0; soe === 1'b1 && k < 50; k++)
            @(posedge clk) #1;
        chk("ser_oe", 24'h1, k > 0 && k < 50);
        tb(0, 0, 16'h0080, 0);
        chk("ser_low", m[0][15:0], r);
        tb(0, 1, 16'h0080, 0);
        chk("ser_high", m[0][23:16], r);
        @(posedge clk) byt <= 1'b1;
        tb(0, 0, 16'h0081, 0);
        chk("byte_hi", m[0][15:8], r);
        report_and_stop();
    end
endmodule
